// File: shared/scoc_map.svh
// Register indices, field positions, reset values and timing counts of the clock controller.
`ifndef SCOC_MAP_SVH
`define SCOC_MAP_SVH

`define SCOC_IDX_CTRL 8'h00
`define SCOC_IDX_RESV 8'h01
`define SCOC_IDX_ID 8'h02

`define SCOC_CTRL_RESET 8'h1F
`define SCOC_RESV_RESET 8'h00

`define SCOC_TEST_BIT 7
`define SCOC_RATIO_MSB 6
`define SCOC_RATIO_LSB 4
`define SCOC_EN_MSB 3

`define SCOC_ADDR_BASE 5'h1B
`define SCOC_BIT_LAST 4'h7
`define SCOC_BIT_ACK 4'h8
`define SCOC_BIT_START 4'hF

`define SCOC_STRAP_SETTLE 2'h2

`define SCOC_SYNC_REF 0
`define SCOC_SYNC_PLL 1
`define SCOC_SYNC_SCL 2
`define SCOC_SYNC_SDA 3
`define SCOC_SYNC_OE 4
`define SCOC_SYNC_MODE 5
`define SCOC_SYNC_A0 6
`define SCOC_SYNC_A1 7

`endif

// File: shared/scoc_pkg.sv
// Types shared by the clock output controller.
package scoc_pkg;

  typedef enum logic [2:0] {
    SCOC_IDLE,
    SCOC_ADDR,
    SCOC_INDEX,
    SCOC_COUNT,
    SCOC_WDATA,
    SCOC_RCOUNT,
    SCOC_RDATA,
    SCOC_IGNORE
  } scoc_state_type;

endpackage

// File: hw/scoc_clock_ctrl.sv
// Output gating, clock path selection and serial configuration slave of the clock generator.
`timescale 1ns/100ps
`include "scoc_map.svh"

// Contract
// - Drive output only when pin and bit high.
// - Disabled outputs float, never fixed level.
// - Enable pin active high, low floats all.
// - PLL mode gives reference times chosen ratio.
// - Eight ratio codes: 3,4,5,6,8,9/2,15/2,15/4.
// - Mode pin: 0 bypass, 1 PLL clock.
// - Four true/complement pairs from one path.
// - Two straps set low address bits.
// - Answer only own strapped address.
// - Host sends start index; device acknowledges.
// - Host sends byte count; device acknowledges.
// - Acknowledge and store each byte consecutively.
// - Byte 0: test, ratio code, four enables.
// - Read: repeated start, count then data bytes.
module scoc_clock_ctrl
  import scoc_pkg::*;
#(
  parameter logic [7:0] ID_VALUE = 8'h5A,
  parameter logic [7:0] READ_COUNT = 8'h03
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic refClk,
  input wire logic pllClk,
  input wire logic smbClk,
  input wire logic smbDataIn,
  input wire logic outputEnablePin,
  input wire logic pllModePin,
  input wire logic slaveAddrStrapLsb,
  input wire logic slaveAddrStrapBit1,
  output logic smbDataOut,
  output logic smbDataOe,
  output logic out0True,
  output logic out0TrueOe,
  output logic out0Comp,
  output logic out0CompOe,
  output logic out1True,
  output logic out1TrueOe,
  output logic out1Comp,
  output logic out1CompOe,
  output logic out2True,
  output logic out2TrueOe,
  output logic out2Comp,
  output logic out2CompOe,
  output logic out3True,
  output logic out3TrueOe,
  output logic out3Comp,
  output logic out3CompOe,
  output logic ratioCodeBit2,
  output logic ratioCodeBit1,
  output logic ratioCodeBit0,
  output logic testMode
);

  localparam int NUM_OUT = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [7:0] syncA;
  logic [7:0] syncB;
  logic sclPrev;
  logic sdaPrev;
  wire logic [7:0] asyncIn = {slaveAddrStrapBit1, slaveAddrStrapLsb, pllModePin,
                              outputEnablePin, smbDataIn, smbClk, pllClk, refClk};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      syncA <= 8'h00;
      syncB <= 8'h00;
      sclPrev <= 1'b0;
      sdaPrev <= 1'b0;
    end else begin
      syncA <= asyncIn;
      syncB <= syncA;
      sclPrev <= syncB[`SCOC_SYNC_SCL];
      sdaPrev <= syncB[`SCOC_SYNC_SDA];
    end
  end

  wire logic sclIn = syncB[`SCOC_SYNC_SCL];
  wire logic sdaIn = syncB[`SCOC_SYNC_SDA];
  wire logic sclRise = sclIn & ~sclPrev;
  wire logic sclFall = ~sclIn & sclPrev;
  wire logic startCond = sclIn & sclPrev & sdaPrev & ~sdaIn;
  wire logic stopCond = sclIn & sclPrev & ~sdaPrev & sdaIn;

  ////////////////////////////////////////////////////////////////////////////////
  // Address straps, caught once shortly after reset release.

  // The straps are read only after the synchroniser has settled so that a
  // metastable first sample can never end up in the address.
  logic [1:0] settleCnt;
  logic strapDone;
  logic [1:0] strapAddr;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      settleCnt <= 2'h0;
      strapDone <= 1'b0;
      strapAddr <= 2'h0;
    end else if (!strapDone) begin
      settleCnt <= settleCnt + 2'h1;
      if (settleCnt == `SCOC_STRAP_SETTLE) begin
        strapDone <= 1'b1;
        strapAddr <= {syncB[`SCOC_SYNC_A1], syncB[`SCOC_SYNC_A0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial slave decodes.

  scoc_state_type state;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg;
  logic [7:0] txShift;
  logic [7:0] regIndex;
  logic isRead;
  logic [7:0] ctrlReg;
  logic [7:0] resvReg;

  wire logic isTx = (state == SCOC_RCOUNT) || (state == SCOC_RDATA);
  wire logic isActive = (state != SCOC_IDLE) && (state != SCOC_IGNORE);
  wire logic byteDone = sclFall & (bitCnt == `SCOC_BIT_LAST);
  wire logic ackDone = sclFall & (bitCnt == `SCOC_BIT_ACK);
  wire logic [6:0] ownAddr = {`SCOC_ADDR_BASE, strapAddr};
  wire logic addrHit = strapDone & (shiftReg[7:1] == ownAddr);
  wire logic hostNack = sclRise & (bitCnt == `SCOC_BIT_ACK) & isTx & sdaIn;
  wire logic wrStrobe = byteDone & (state == SCOC_WDATA);

  logic [7:0] readData;
  always_comb begin
    case (regIndex)
      `SCOC_IDX_CTRL: readData = ctrlReg;
      `SCOC_IDX_RESV: readData = resvReg;
      `SCOC_IDX_ID: readData = ID_VALUE;
      default: readData = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial slave state machine. The data line is only ever pulled low or
  // released, and it changes on the falling clock edge so that a level the
  // device drives can never look like a start or stop to the host.

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= SCOC_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      txShift <= 8'h00;
      regIndex <= 8'h00;
      isRead <= 1'b0;
      smbDataOut <= 1'b0;
      smbDataOe <= 1'b0;
    end else if (startCond) begin
      state <= SCOC_ADDR;
      // The clock fall that closes a start is not a data bit, so the count
      // begins one below zero and wraps to zero on that fall.
      bitCnt <= `SCOC_BIT_START;
      smbDataOe <= 1'b0;
    end else if (stopCond) begin
      state <= SCOC_IDLE;
      bitCnt <= 4'h0;
      smbDataOe <= 1'b0;
    end else if (hostNack) begin
      state <= SCOC_IGNORE;
    end else if (sclRise && !isTx && (bitCnt != `SCOC_BIT_ACK)) begin
      shiftReg <= {shiftReg[6:0], sdaIn};
    end else if (sclFall && !isActive) begin
      smbDataOe <= 1'b0;
    end else if (sclFall) begin
      bitCnt <= (bitCnt == `SCOC_BIT_ACK) ? 4'h0 : bitCnt + 4'h1;
      if (isTx && (bitCnt < `SCOC_BIT_LAST) && !ackDone) begin
        txShift <= {txShift[6:0], 1'b0};
        smbDataOe <= ~txShift[6];
      end else if (byteDone) begin
        // Receive states acknowledge here; transmit states let the host answer.
        smbDataOe <= ~isTx;
      end
      case (state)
        SCOC_ADDR: begin
          if (byteDone && !addrHit) begin
            state <= SCOC_IGNORE;
            smbDataOe <= 1'b0;
          end else if (byteDone) begin
            isRead <= shiftReg[0];
          end else if (ackDone && isRead) begin
            state <= SCOC_RCOUNT;
            txShift <= READ_COUNT;
            smbDataOe <= ~READ_COUNT[7];
          end else if (ackDone) begin
            state <= SCOC_INDEX;
            smbDataOe <= 1'b0;
          end
        end
        SCOC_INDEX: begin
          if (byteDone) begin
            regIndex <= shiftReg;
          end else if (ackDone) begin
            state <= SCOC_COUNT;
            smbDataOe <= 1'b0;
          end
        end
        SCOC_COUNT: begin
          if (ackDone) begin
            state <= SCOC_WDATA;
            smbDataOe <= 1'b0;
          end
        end
        SCOC_WDATA: begin
          if (byteDone) begin
            regIndex <= regIndex + 8'h01;
          end else if (ackDone) begin
            smbDataOe <= 1'b0;
          end
        end
        SCOC_RCOUNT, SCOC_RDATA: begin
          if (ackDone) begin
            state <= SCOC_RDATA;
            txShift <= readData;
            smbDataOe <= ~readData[7];
            regIndex <= regIndex + 8'h01;
          end
        end
        default: begin
          smbDataOe <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers. The identity byte is read only; writes to it and
  // to indices beyond the map are acknowledged and dropped.

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrlReg <= `SCOC_CTRL_RESET;
      resvReg <= `SCOC_RESV_RESET;
    end else if (wrStrobe && (regIndex == `SCOC_IDX_CTRL)) begin
      ctrlReg <= shiftReg;
    end else if (wrStrobe && (regIndex == `SCOC_IDX_RESV)) begin
      resvReg <= shiftReg;
    end
  end

  // The ratio code goes to the analog multiplier; each of the eight codes
  // names one of the supported ratios.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ratioCodeBit2 <= 1'b0;
      ratioCodeBit1 <= 1'b0;
      ratioCodeBit0 <= 1'b0;
      testMode <= 1'b0;
    end else begin
      ratioCodeBit2 <= ctrlReg[`SCOC_RATIO_MSB];
      ratioCodeBit1 <= ctrlReg[`SCOC_RATIO_MSB - 1];
      ratioCodeBit0 <= ctrlReg[`SCOC_RATIO_LSB];
      testMode <= ctrlReg[`SCOC_TEST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock path and output buffers.

  // The sampled clocks carry only the sampling rate of the system clock; the
  // real fan-out path sits in the analog buffers, which this logic steers.
  wire logic pathClk = syncB[`SCOC_SYNC_MODE] ? syncB[`SCOC_SYNC_PLL]
                                               : syncB[`SCOC_SYNC_REF];
  wire logic pinEnable = syncB[`SCOC_SYNC_OE];

  logic [NUM_OUT-1:0] trueQ;
  logic [NUM_OUT-1:0] compQ;
  logic [NUM_OUT-1:0] oeQ;

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : gOut
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          trueQ[g] <= 1'b0;
          compQ[g] <= 1'b0;
          oeQ[g] <= 1'b0;
        end else begin
          trueQ[g] <= pathClk;
          compQ[g] <= ~pathClk;
          oeQ[g] <= pinEnable & ctrlReg[`SCOC_EN_MSB - g];
        end
      end
    end
  endgenerate

  // A disabled pair drops its enable and floats.
  assign out0True = trueQ[0];
  assign out0Comp = compQ[0];
  assign out0TrueOe = oeQ[0];
  assign out0CompOe = oeQ[0];
  assign out1True = trueQ[1];
  assign out1Comp = compQ[1];
  assign out1TrueOe = oeQ[1];
  assign out1CompOe = oeQ[1];
  assign out2True = trueQ[2];
  assign out2Comp = compQ[2];
  assign out2TrueOe = oeQ[2];
  assign out2CompOe = oeQ[2];
  assign out3True = trueQ[3];
  assign out3Comp = compQ[3];
  assign out3TrueOe = oeQ[3];
  assign out3CompOe = oeQ[3];

endmodule

// File: test/scoc_clock_ctrl_assertions.sv
// Pin-level concurrent checks for the clock output controller.
`timescale 1ns/100ps
module scoc_clock_ctrl_assertions (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic refClk,
  input wire logic pllClk,
  input wire logic smbClk,
  input wire logic pllModePin,
  input wire logic outputEnablePin,
  input wire logic smbDataOe,
  input wire logic out0True,
  input wire logic out0Comp,
  input wire logic out3True,
  input wire logic out0TrueOe,
  input wire logic out0CompOe,
  input wire logic out3TrueOe,
  input wire logic ratioCodeBit2,
  input wire logic ratioCodeBit1,
  input wire logic ratioCodeBit0,
  input wire logic testMode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic [3:0] cfg = {testMode, ratioCodeBit2, ratioCodeBit1, ratioCodeBit0};
  ////////////////////////////////////////////////////////////////
  a_pin_low_floats: assert property (
    !outputEnablePin [*5] |-> !out0TrueOe && !out3TrueOe) else $error("pair driven, pin low");
  a_pair_oe_equal: assert property (
    out0TrueOe == out0CompOe) else $error("true and comp enables differ");
  a_comp_inverse: assert property (
    $past(rstn) |-> out0Comp != out0True) else $error("comp side not inverse");
  a_pairs_shared: assert property (
    out0True == out3True) else $error("pairs follow different paths");
  // Mode is held a while so the sync depth of the mode pin cannot matter.
  a_bypass_path: assert property (
    (rstn && !pllModePin) [*6] |-> out0True == $past(refClk, 3)) else $error("bypass path");
  a_pll_path: assert property (
    (rstn && pllModePin) [*6] |-> out3True == $past(pllClk, 3)) else $error("pll path");
  a_ack_scl_low: assert property (
    $changed(smbDataOe) |-> !smbClk && !$past(smbClk, 2)) else $error("data moved, clock high");
  a_ratio_scl_low: assert property (
    $past(rstn, 2) && $changed(cfg) |-> !smbClk) else $error("config moved off a byte end");
  cover property ($rose(smbDataOe));
  cover property ($rose(testMode));
  cover property (pllModePin && $rose(out3True));
  cover property ($fell(out0TrueOe));
endmodule

bind scoc_clock_ctrl scoc_clock_ctrl_assertions i_chk (.sys_clk, .rstn, .refClk, .pllClk,
  .smbClk, .pllModePin, .outputEnablePin, .smbDataOe, .out0True, .out0Comp, .out3True,
  .out0TrueOe, .out0CompOe, .out3TrueOe, .ratioCodeBit2, .ratioCodeBit1, .ratioCodeBit0,
  .testMode);

// File: test/scoc_smbus_host.sv
// Behavioural serial bus host framing writes and reads on clock and data lines.
`timescale 1ns/100ps
module scoc_smbus_host (
  output logic smbClk,
  output logic sdaLow,
  input wire logic sdaWire,
  output logic resValid,
  output logic [8:0] resData
);
  initial begin
    smbClk = 1'b1;
    sdaLow = 1'b0;
    resValid = 1'b0;
    resData = 9'h000;
  end
  ////////////////////////////////////////////////////////////////
  // Start and repeated start share one shape, so either is entered the same way.
  task automatic start();
    sdaLow = 1'b0;
    #35 smbClk = 1'b1;
    #50 sdaLow = 1'b1;
    #50 smbClk = 1'b0;
    #40;
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    #35 smbClk = 1'b1;
    #50 sdaLow = 1'b0;
    #100;
  endtask
  // Nine bits, most significant first; the wire level is reported, not what was sent.
  task automatic xfer(input logic [8:0] tx);
    logic [8:0] rx;
    for (int i = 8; i >= 0; i--) begin
      sdaLow = !tx[i];
      #35 smbClk = 1'b1;
      #25 rx[i] = sdaWire;
      #25 smbClk = 1'b0;
      #40;
    end
    resData = {rx[0], rx[8:1]};
    resValid = 1'b1;
    #1 resValid = 1'b0;
  endtask
endmodule

// File: test/test_smbus_clock_output_control.sv
// Self-checking bench: serial writes and reads, pin gating, strap address, clock path.
`timescale 1ns/100ps
module test_smbus_clock_output_control;
  localparam logic [7:0] ID = 8'h5A; // Arbitrary value.
  logic sys_clk = 1'b0, rstn = 1'b0, refClk = 1'b0, pllClk = 1'b0, oePin = 1'b1;
  logic mode = 1'b0, strap0 = 1'b0, strap1 = 1'b0, pinValid = 1'b0;
  logic smbClk, sdaLow, resValid, smbDataOut, smbDataOe, testMode;
  logic [8:0] resData;
  logic [3:0] t, c, to, co;
  logic [2:0] ratio;
  logic [8:0] expQ[$];
  logic [31:0] seed = 32'h00018159;
  int mismatches = 0, checks = 0;
  wire logic sdaWire = !sdaLow && !(smbDataOe && !smbDataOut);
  wire logic [8:0] pinData = {testMode, ratio, to[0], to[1], to[2], to[3], smbDataOe};
  scoc_clock_ctrl #(.ID_VALUE(ID), .READ_COUNT(8'h03)) i_dut (.sys_clk(sys_clk), .rstn(rstn),
    .refClk(refClk), .pllClk(pllClk), .smbClk(smbClk), .smbDataIn(sdaWire),
    .outputEnablePin(oePin), .pllModePin(mode), .slaveAddrStrapLsb(strap0),
    .slaveAddrStrapBit1(strap1), .smbDataOut(smbDataOut), .smbDataOe(smbDataOe),
    .out0True(t[0]), .out0TrueOe(to[0]), .out0Comp(c[0]), .out0CompOe(co[0]),
    .out1True(t[1]), .out1TrueOe(to[1]), .out1Comp(c[1]), .out1CompOe(co[1]),
    .out2True(t[2]), .out2TrueOe(to[2]), .out2Comp(c[2]), .out2CompOe(co[2]),
    .out3True(t[3]), .out3TrueOe(to[3]), .out3Comp(c[3]), .out3CompOe(co[3]),
    .ratioCodeBit2(ratio[2]), .ratioCodeBit1(ratio[1]), .ratioCodeBit0(ratio[0]),
    .testMode(testMode));
  scoc_smbus_host i_host (.smbClk(smbClk), .sdaLow(sdaLow), .sdaWire(sdaWire),
    .resValid(resValid), .resData(resData));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    seed <= xs(seed);
    refClk <= seed[3];
    pllClk <= seed[11];
  end
  always @(posedge resValid or posedge pinValid) begin
    logic [8:0] got;
    got = resValid ? resData : pinData;
    checks++;
    if (expQ.size() == 0 || got !== expQ[0]) begin
      mismatches++;
      $display("mismatch at %0t: got %h", $time, got);
    end
    if (expQ.size() != 0) void'(expQ.pop_front());
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (expQ.size() != 0) mismatches++;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic reset(input logic [1:0] s);
    @(posedge sys_clk) rstn <= 1'b0;
    {strap1, strap0} <= s;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (12) @(posedge sys_clk);
  endtask
  task automatic sendB(input logic [7:0] b, input logic nack);
    expQ.push_back({nack, b});
    i_host.xfer({b, 1'b1});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] idx, input logic [15:0] d,
                    input logic nack);
    i_host.start();
    sendB(a, nack);
    sendB(idx, nack);
    sendB(8'h02, nack);
    sendB(d[15:8], nack);
    sendB(d[7:0], nack);
    i_host.stop();
  endtask
  task automatic rd(input logic [23:0] e);
    i_host.start();
    sendB(8'hD8, 1'b0);
    sendB(8'h00, 1'b0);
    i_host.start();
    sendB(8'hD9, 1'b0);
    expQ.push_back(9'h003);
    i_host.xfer(9'h1FE);
    for (int i = 2; i >= 0; i--) begin
      expQ.push_back({i == 0, e[8*i +: 8]});
      i_host.xfer({8'hFF, i == 0});
    end
    i_host.stop();
  endtask
  task automatic pins(input logic [8:0] e, input string n);
    repeat (6) @(posedge sys_clk);
    expQ.push_back(e);
    #1 pinValid = 1'b1;
    #1 pinValid = 1'b0;
    checks++;
    if (c !== ~t || co !== to || t !== {4{t[0]}} || smbDataOut !== 1'b0) begin
      mismatches++;
      $display("mismatch at %0t: pair sides or data level", $time);
    end
    $display("test %s done", n);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    #600000;
    mismatches++;
    test_done();
  end
  initial begin
    logic [7:0] v;
    reset(2'b00);
    pins(9'h03E, "reset");
    @(posedge sys_clk) oePin <= 1'b0;
    pins(9'h020, "pin low");
    @(posedge sys_clk) oePin <= 1'b1;
    mode <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      v = {seed[7], k[2:0], seed[3:0]};
      wr(8'hD8, 8'h00, {v, 8'h00}, 1'b0);
      pins({v, 1'b0}, "ratio code");
    end
    wr(8'hD8, 8'h01, 16'hA533, 1'b0);
    rd({v, 8'hA5, ID});
    pins({v, 1'b0}, "block read");
    @(posedge sys_clk) mode <= 1'b0;
    wr(8'hDA, 8'h00, 16'h0000, 1'b1);
    pins({v, 1'b0}, "foreign address");
    reset(2'b11);
    wr(8'hD8, 8'h00, 16'h0000, 1'b1);
    wr(8'hDE, 8'h00, 16'h7100, 1'b0);
    pins(9'h0E2, "strapped address");
    @(posedge sys_clk) oePin <= 1'b0;
    pins(9'h0E0, "pin gating");
    test_done();
  end
endmodule
